// *** shared/pcr_pkg.sv ***
/*
  Constants and carrier types for the common peripheral register template:
  word offsets inside the peripheral window, reset values, window sizes.
  Assumes a 32-bit peripheral bus with APB-style two-phase transfers.

*/
`default_nettype none

package pcr_pkg;

  localparam int unsigned DATA_W        = 32;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned WIN_PERIPH_B  = 16384;
  localparam int unsigned WIN_VIU_B     = 4096;

  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_MODE       = 8'h04;
  localparam logic [7:0] OFF_STAT       = 8'h08;
  localparam logic [7:0] OFF_FEAT_EN    = 8'h10;
  localparam logic [7:0] OFF_FEAT_DIS   = 8'h14;
  localparam logic [7:0] OFF_FEAT_STAT  = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN     = 8'h20;
  localparam logic [7:0] OFF_IRQ_DIS    = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h28;

  localparam logic [31:0] RST_MODE      = 32'h0000_0000;
  localparam logic [31:0] RST_FEAT      = 32'h0000_0000;
  localparam logic [31:0] RST_IMASK     = 32'h0000_0000;

  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pcr_req_t;

  typedef struct packed {
    logic              ready;
    logic              slverr;
    logic [DATA_W-1:0] rdata;
  } pcr_rsp_t;

endpackage

`default_nettype wire

// *** hw/pcr_periph_regs.sv ***
/*
  Common register front end of one peripheral: command, mode, status and
  two enable/disable/status groups (features and interrupt mask).
  Assumes the bus master on the same clock; APB-style setup/access phases.
*/
`timescale 1ns/1ps
`default_nettype none

module pcr_periph_regs
  import pcr_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = 32'hFFFE_0000,
  parameter int unsigned WIN_B     = WIN_PERIPH_B,
  parameter logic [31:0] CMD_USED  = 32'h0000_00FF,
  parameter logic [31:0] MODE_USED = 32'h0000_FFFF,
  parameter logic [31:0] STAT_USED = 32'h0000_FFFF,
  parameter logic [31:0] FEAT_USED = 32'h0000_00FF,
  parameter logic [31:0] IRQ_USED  = 32'h0000_FFFF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire pcr_req_t    req_i,
  output pcr_rsp_t         rsp_o,
  output logic [31:0]      cmd_o,
  output logic [31:0]      mode_o,
  input  wire logic [31:0] status_i,
  output logic [31:0]      feat_o,
  output logic [31:0]      irq_mask_o
);

  localparam int unsigned WIN_LSB = $clog2(WIN_B);

  logic        in_win;
  logic [31:0] woff;
  logic        setup_ph;
  logic        wr_acc;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic        err_d;
  logic        err_q;
  logic [31:0] cmd_q;
  logic [31:0] mode_q;
  logic [31:0] feat_q;
  logic [31:0] imask_q;

  // window decode; low two bits dropped so any size becomes a word access
  assign in_win   = (req_i.addr[31:WIN_LSB] == BASE_ADDR[31:WIN_LSB]);
  assign woff     = {req_i.addr[31:2], 2'b00} & ((32'h1 << WIN_LSB) - 32'h1);
  assign setup_ph = req_i.sel && !req_i.enable;
  assign wr_acc   = req_i.sel && req_i.enable && req_i.write && err_q;

  // read data prepared in setup so it leaves a flop in access
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    if (!in_win) begin
      err_d = 1'b1;
    end else if (woff[7:0] == OFF_MODE && woff[31:8] == 24'h0) begin
      rdata_d = mode_q & MODE_USED;
    end else if (woff[7:0] == OFF_STAT && woff[31:8] == 24'h0) begin
      rdata_d = status_i & STAT_USED;
    end else if (woff[7:0] == OFF_FEAT_STAT && woff[31:8] == 24'h0) begin
      rdata_d = feat_q;
    end else if (woff[7:0] == OFF_IRQ_MASK && woff[31:8] == 24'h0) begin
      rdata_d = imask_q;
    end else begin
      rdata_d = 32'h0000_0000;
    end
  end

  // err_q holds "inside window" polarity inverted: high means accepted
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (setup_ph) begin
      rdata_q <= req_i.write ? 32'h0000_0000 : rdata_d;
      err_q   <= !err_d;
    end
  end

  assign rsp_o = '{ready:  1'b1,
                   slverr: req_i.sel && req_i.enable && !err_q,
                   rdata:  rdata_q};

  // commands: one-cycle pulse per written one, zeros do nothing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= 32'h0000_0000;
    end else if (wr_acc && woff == {24'h0, OFF_CTRL}) begin
      cmd_q <= req_i.wdata & CMD_USED;
    end else begin
      cmd_q <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= RST_MODE;
    end else if (wr_acc && woff == {24'h0, OFF_MODE}) begin
      mode_q <= req_i.wdata & MODE_USED;
    end
  end

  // shadow groups: no read-modify-write needed by software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      feat_q <= RST_FEAT;
    end else if (wr_acc && woff == {24'h0, OFF_FEAT_EN}) begin
      feat_q <= feat_q | (req_i.wdata & FEAT_USED);
    end else if (wr_acc && woff == {24'h0, OFF_FEAT_DIS}) begin
      feat_q <= feat_q & ~(req_i.wdata & FEAT_USED);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      imask_q <= RST_IMASK;
    end else if (wr_acc && woff == {24'h0, OFF_IRQ_EN}) begin
      imask_q <= imask_q | (req_i.wdata & IRQ_USED);
    end else if (wr_acc && woff == {24'h0, OFF_IRQ_DIS}) begin
      imask_q <= imask_q & ~(req_i.wdata & IRQ_USED);
    end
  end

  assign cmd_o      = cmd_q;
  assign mode_o     = mode_q;
  assign feat_o     = feat_q;
  assign irq_mask_o = imask_q;

  // helper: offset and data of the previous cycle, wr_seen_q marks an accepted write in it
  logic        wr_seen_q;
  logic [31:0] woff_q;
  logic [31:0] wdat_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_seen_q <= 1'b0;
      woff_q    <= 32'h0000_0000;
      wdat_q    <= 32'h0000_0000;
    end else begin
      wr_seen_q <= wr_acc;
      woff_q    <= woff;
      wdat_q    <= req_i.wdata;
    end
  end

  // checks below lean on the helper flops for the write seen last cycle
  AST_CMD_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_q != 32'h0) |=> (cmd_q == 32'h0) || $past(wr_acc))
    else $error("command pulse held without a new write");
  AST_CMD_ZERO_NOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_acc && woff == {24'h0, OFF_CTRL} |=> cmd_q == (wdat_q & CMD_USED))
    else $error("command bits differ from written ones");
  AST_CMD_ONLY_CTRL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_acc && woff == {24'h0, OFF_CTRL}) |=> cmd_q == 32'h0)
    else $error("command pulse without a control write");
  AST_MODE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_seen_q && woff_q == {24'h0, OFF_MODE}) |-> $stable(mode_q))
    else $error("mode changed without a mode write");
  AST_MODE_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    setup_ph && !req_i.write && in_win && woff == {24'h0, OFF_MODE}
    |=> rsp_o.rdata == ($past(mode_q) & MODE_USED))
    else $error("mode read does not show the mode register");
  AST_STAT_RO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    setup_ph && !req_i.write && in_win && woff == {24'h0, OFF_STAT}
    |=> rsp_o.rdata == ($past(status_i) & STAT_USED))
    else $error("status read does not show live status");
  AST_FEAT_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_acc && woff == {24'h0, OFF_FEAT_EN}
    |=> feat_q == ($past(feat_q) | (wdat_q & FEAT_USED)))
    else $error("enable write did not set just the selected bits");
  AST_FEAT_CLR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_acc && woff == {24'h0, OFF_FEAT_DIS}
    |=> feat_q == ($past(feat_q) & ~(wdat_q & FEAT_USED)))
    else $error("disable write did not clear just the selected bits");
  AST_FEAT_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_seen_q && (woff_q == {24'h0, OFF_FEAT_EN} || woff_q == {24'h0, OFF_FEAT_DIS}))
    |-> $stable(feat_q))
    else $error("feature status changed without an enable or disable write");
  AST_IMASK_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_acc && woff == {24'h0, OFF_IRQ_EN}
    |=> (imask_q & wdat_q & IRQ_USED) == (wdat_q & IRQ_USED))
    else $error("interrupt enable left a selected bit clear");
  AST_IMASK_ONLY_SEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_acc && woff == {24'h0, OFF_IRQ_EN}
    |=> (imask_q & ~(wdat_q & IRQ_USED)) == ($past(imask_q) & ~(wdat_q & IRQ_USED)))
    else $error("interrupt enable touched unselected bits");
  AST_IMASK_DIS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_acc && woff == {24'h0, OFF_IRQ_DIS} |=> (imask_q & wdat_q & IRQ_USED) == 32'h0)
    else $error("interrupt disable left a selected bit set");
  AST_IMASK_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_seen_q && (woff_q == {24'h0, OFF_IRQ_EN} || woff_q == {24'h0, OFF_IRQ_DIS}))
    |-> $stable(imask_q))
    else $error("interrupt mask changed without an enable or disable write");
  AST_WO_READ_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    setup_ph && !req_i.write && woff == {24'h0, OFF_CTRL} |=> rsp_o.rdata == 32'h0)
    else $error("write-only location read non-zero");
  AST_OUT_WIN_ERR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    setup_ph && !in_win ##1 req_i.sel && req_i.enable |-> rsp_o.slverr)
    else $error("access outside window not flagged");
  AST_IN_WIN_OK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    setup_ph && in_win ##1 req_i.sel && req_i.enable |-> !rsp_o.slverr)
    else $error("access inside window flagged as error");
  AST_OUT_WIN_NO_WR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    setup_ph && !in_win ##1 req_i.sel && req_i.enable && req_i.write
    |=> $stable(mode_q) && $stable(feat_q) && $stable(imask_q))
    else $error("write outside window changed a register");
  AST_LOW_BITS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_acc && req_i.addr[1:0] != 2'b00 && woff == {24'h0, OFF_MODE}
    |=> mode_q == (wdat_q & MODE_USED))
    else $error("unaligned mode write did not land on the word");

  COV_CMD: cover property (@(posedge clk_i) disable iff (!rst_n_i) cmd_q != 32'h0);
  COV_FEAT_ON_OFF: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    feat_q != 32'h0 ##[1:20] feat_q == 32'h0);
  COV_BYTE_ADDR: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_acc && req_i.addr[1:0] == 2'b01);
  COV_ERR: cover property (@(posedge clk_i) disable iff (!rst_n_i) rsp_o.slverr);
  COV_STAT_READ: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    setup_ph && !req_i.write && woff == {24'h0, OFF_STAT});

endmodule

`default_nettype wire

// *** dv/pcr_bus_master.sv ***
/*
  Bus master model for the processor side: APB-style setup/access transfers.
  Assumes the register front end is clocked by the same rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module pcr_bus_master
  import pcr_pkg::*;
(
  input  wire logic     clk_i,
  input  wire pcr_rsp_t rsp_i,
  output pcr_req_t      req_o
);
  initial req_o = '0;

  // released bus shows inverted values, so stale data cannot pass for a match
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic ok);
    @(posedge clk_i);
    req_o <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk_i);
    req_o.enable <= 1'b1;
    ok = 1'b0;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk_i);
      ok = (rsp_i.ready === 1'b1);
    end
    req_o <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

`default_nettype wire

// *** dv/tb_top.sv ***
/*
  Self-checking bench for the peripheral register front end.
  Assumes the bus master model drives the request side.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top import pcr_pkg::*;;
  localparam logic [31:0] BASE = 32'hFFFE_0000;
  localparam logic [31:0] CMDU = 32'h0000_00FF;
  localparam logic [31:0] MODU = 32'h0000_FFFF;
  localparam logic [31:0] STAU = 32'h0000_FFFF;
  logic        clk_i;
  logic        rst_n_i;
  logic [31:0] status_i;
  pcr_req_t    req;
  pcr_rsp_t    rsp;
  logic [31:0] cmd, mode, feat, imask;
  int          fails;
  int          n_tests;
  logic [33:0] exp_q[$];
  logic [33:0] x;
  logic [31:0] d, m, s;
  logic        ok;
  logic [7:0]  en_off[2] = '{OFF_FEAT_EN, OFF_IRQ_EN};
  logic [7:0]  dis_off[2] = '{OFF_FEAT_DIS, OFF_IRQ_DIS};
  logic [7:0]  st_off[2] = '{OFF_FEAT_STAT, OFF_IRQ_MASK};
  logic [31:0] used[2] = '{32'h0000_00FF, 32'h0000_FFFF};

  pcr_periph_regs #(.BASE_ADDR(BASE), .CMD_USED(CMDU), .MODE_USED(MODU), .STAT_USED(STAU),
    .FEAT_USED(32'h0000_00FF), .IRQ_USED(32'h0000_FFFF)) u_pcr_periph_regs (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .req_i(req), .rsp_o(rsp), .cmd_o(cmd), .mode_o(mode),
    .status_i(status_i), .feat_o(feat), .irq_mask_o(imask));
  pcr_bus_master u_pcr_bus_master (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    if (exp_q.size() != 0) begin
      fails++;
      $display("[FAIL] %0t %0d expected answers never seen", $time, exp_q.size());
    end
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      fails++;
      $display("[FAIL] %0t output %h expected %h", $time, got, want);
    end
  endtask

  // expectation note: {is read, slverr, read data}
  task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] dd,
                     input logic [33:0] note);
    exp_q.push_back(note);
    u_pcr_bus_master.xfer(wr, a, dd, ok);
    if (!ok) begin
      fails++;
      print_verdict();
    end
  endtask

  always @(posedge clk_i) begin
    if (req.sel && req.enable && rsp.ready) begin
      n_tests++;
      x = (exp_q.size() > 0) ? exp_q.pop_front() : {2'b11, ~rsp.rdata};
      if (rsp.slverr !== x[32] || (x[33] && rsp.rdata !== x[31:0])) begin
        fails++;
        $display("[FAIL] %0t answer %h err %b wrong", $time, rsp.rdata, rsp.slverr);
      end
    end
  end

  initial begin
    void'($urandom(32'h9C79_9E17));
    fails = 0;
    n_tests = 0;
    rst_n_i = 1'b0;
    status_i = 32'h0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk(mode | feat | imask, 32'h0);
    acc(0, BASE + OFF_MODE, 0, {2'b10, 32'h0});
    acc(0, BASE + OFF_CTRL, 0, {2'b10, 32'h0});
    acc(0, BASE + 32'h30, 0, {2'b10, 32'h0});
    m = $urandom() & MODU;
    acc(1, BASE + OFF_MODE + 32'h2, m, 0);
    acc(0, BASE + OFF_MODE + 32'h1, 0, {2'b10, m});
    d = ($urandom() & CMDU) | 32'h1;
    acc(1, BASE + OFF_CTRL, d, 0);
    #1 chk(cmd, d);
    s = $urandom();
    @(posedge clk_i);
    status_i <= s;
    #1 chk(cmd, 32'h0);
    acc(1, BASE + OFF_STAT, ~s & STAU, 0);
    acc(0, BASE + OFF_STAT, 0, {2'b10, s & STAU});
    for (int g = 0; g < 2; g++) begin
      s = 32'h0;
      for (int k = 0; k < 4; k++) begin
        d = $urandom() & used[g];
        acc(1, BASE + (k[0] ? dis_off[g] : en_off[g]), d, 0);
        s = k[0] ? (s & ~d) : (s | d);
        #1 chk(g ? imask : feat, s);
        acc(1, BASE + st_off[g], ~s & used[g], 0);
        acc(0, BASE + st_off[g], 0, {2'b10, s});
        acc(0, BASE + dis_off[g], 0, {2'b10, 32'h0});
      end
    end
    // mode word (offset OFF_MODE) just past the window must be refused
    acc(1, BASE + WIN_PERIPH_B + OFF_MODE, 32'h1, {2'b01, 32'h0});
    acc(0, BASE + WIN_PERIPH_B + OFF_MODE, 0, {2'b11, 32'h0});
    acc(0, BASE + WIN_PERIPH_B - 32'h4, 0, {2'b10, 32'h0});
    #1 chk(mode, m);
    print_verdict();
  end
endmodule

`default_nettype wire
